/* include/css_pkg.sv */
// shared constants for the charge session status controller
package css_pkg;

   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;

   // times in milliseconds, then in ref_clk cycles
   localparam int unsigned INIT_TIME_MS    = 500;
   localparam int unsigned BLINK_PERIOD_MS = 1000;
   localparam int unsigned REQ_TIMEOUT_MS  = 1500;

   localparam int unsigned INIT_CYC        = INIT_TIME_MS * CLK_PER_MS;
   localparam int unsigned BLINK_CYC       = BLINK_PERIOD_MS * CLK_PER_MS;
   localparam int unsigned REQ_TIMEOUT_CYC = REQ_TIMEOUT_MS * CLK_PER_MS;

   localparam int unsigned LEVEL_W         = 8;
   localparam logic [7:0]  LEVEL_RST       = 8'h00;
   localparam logic [31:0] TIMER_RST       = 32'h0000_0000;
   localparam logic [2:0]  SYNC_RST        = 3'h0;

   typedef enum logic [2:0] {
      CSS_INIT,
      CSS_STANDBY,
      CSS_CONFIG,
      CSS_TRANSFER,
      CSS_FOD_FAULT,
      CSS_ERR_FAULT,
      CSS_COMPLETE
   } css_state_t;

endpackage

/* logic/css_session_ctrl.sv */
// charge session state machine with status indicator drive
//
// How it works
// (RULE_01) after reset sit in init with green lit for half a second
// (RULE_02) standby searches for a receiver with both indicators dark
// (RULE_03) found receiver: collect its instructions first, then deliver power
// (RULE_04) during transfer green blinks once per second
// (RULE_05) foreign object aborts; red blinks per second until removal
// (RULE_06) any other error aborts; red steady until receiver removed
// (RULE_07) errors: link failure, excess voltage, current, power, temperature
// (RULE_08) receiver wants no more power: complete state, green steady
// (RULE_09) receiver removed from any state returns the controller to standby; removal during init is ignored until init ends
// (RULE_10) power requests stopping ends the current transaction
// (RULE_11) the receiver keeps sending power requests during a session
// (RULE_12) delivered level follows each new amount the receiver requests
// (RULE_13) power enabled only with receiver present, capped at its request
// (RULE_14) blink period from a clock counter, roughly half on, half off
`timescale 1ns/1ps

module css_session_ctrl #(
   parameter int unsigned INIT_CYC        = css_pkg::INIT_CYC,
   parameter int unsigned BLINK_CYC       = css_pkg::BLINK_CYC,
   parameter int unsigned REQ_TIMEOUT_CYC = css_pkg::REQ_TIMEOUT_CYC
) (
   input  wire logic                        ref_clk,
   input  wire logic                        resetn,
   input  wire logic                        rx_present_pin,
   input  wire logic                        fod_detect_pin,
   input  wire logic                        rx_config_done,
   input  wire logic                        rx_req_valid,
   input  wire logic [css_pkg::LEVEL_W-1:0] rx_req_level,
   input  wire logic                        rx_end_power,
   input  wire logic                        comm_error,
   input  wire logic                        over_volt,
   input  wire logic                        over_curr,
   input  wire logic                        over_power,
   input  wire logic                        over_temp,
   output logic                             led_green,
   output logic                             led_red,
   output logic                             power_en,
   output logic [css_pkg::LEVEL_W-1:0]      power_level,
   output css_pkg::css_state_t              session_state
);

   generate
      if (INIT_CYC < 1 || BLINK_CYC < 2 || REQ_TIMEOUT_CYC < 1)
      begin : g_bad_param
         $error("css_session_ctrl: cycle counts out of range");
      end
   endgenerate

   localparam logic [31:0] INIT_LAST  = 32'(INIT_CYC - 1);
   localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYC - 1);
   localparam logic [31:0] BLINK_HALF = 32'(BLINK_CYC / 2);
   localparam logic [31:0] REQ_LAST   = 32'(REQ_TIMEOUT_CYC - 1);

   // pin synchronisers: three-stage shift, stage 0 feeds stage 1 and stage 1 feeds stage 2
   logic [2:0]                   pres_sync_reg;
   logic [2:0]                   pres_sync_next;
   logic [2:0]                   fod_sync_reg;
   logic [2:0]                   fod_sync_next;
   logic                         present_reg;
   logic                         present_next;
   logic                         fod_reg;
   logic                         fod_next;

   css_pkg::css_state_t          state_reg;
   css_pkg::css_state_t          state_next;
   logic [31:0]                  timer_reg;
   logic [31:0]                  timer_next;
   logic [31:0]                  wdog_reg;
   logic [31:0]                  wdog_next;
   logic [css_pkg::LEVEL_W-1:0]  level_reg;
   logic [css_pkg::LEVEL_W-1:0]  level_next;
   logic                         green_reg;
   logic                         green_next;
   logic                         red_reg;
   logic                         red_next;
   logic                         pwr_reg;
   logic                         pwr_next;
   logic                         any_error;
   logic                         blink_on;

   always_comb
   begin
      pres_sync_next = {pres_sync_reg[1:0], rx_present_pin};
      fod_sync_next  = {fod_sync_reg[1:0], fod_detect_pin};
      // a change is accepted once the last two stages agree
      present_next   = present_reg;
      fod_next       = fod_reg;
      if (pres_sync_reg[1] == pres_sync_reg[2])
      begin
         present_next = pres_sync_reg[2];
      end
      if (fod_sync_reg[1] == fod_sync_reg[2])
      begin
         fod_next = fod_sync_reg[2];
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pres_sync_reg <= css_pkg::SYNC_RST;
         fod_sync_reg  <= css_pkg::SYNC_RST;
         present_reg   <= 1'b0;
         fod_reg       <= 1'b0;
      end
      else
      begin
         pres_sync_reg <= pres_sync_next;
         fod_sync_reg  <= fod_sync_next;
         present_reg   <= present_next;
         fod_reg       <= fod_next;
      end
   end

   assign any_error = comm_error | over_volt | over_curr | over_power
                    | over_temp; // RULE_07
   // the timer clears on each state change and wraps every period in blinking states, so the phase
   // restarts cleanly on entry
   assign blink_on  = (timer_next < BLINK_HALF); // RULE_14

   always_comb
   begin
      state_next = state_reg;
      timer_next = timer_reg + 32'h0000_0001;
      wdog_next  = TIMER_RST_F();
      level_next = level_reg;
      case (state_reg)
         css_pkg::CSS_INIT:
         begin
            if (timer_reg >= INIT_LAST) // RULE_01
            begin
               state_next = css_pkg::CSS_STANDBY;
            end
         end
         css_pkg::CSS_STANDBY:
         begin
            if (present_reg)
            begin
               state_next = css_pkg::CSS_CONFIG; // RULE_03
            end
         end
         css_pkg::CSS_CONFIG:
         begin
            wdog_next = wdog_reg + 32'h0000_0001;
            if (any_error)
            begin
               state_next = css_pkg::CSS_ERR_FAULT; // RULE_06
            end
            else if (rx_config_done)
            begin
               state_next = css_pkg::CSS_TRANSFER; // RULE_03
            end
            else if (wdog_reg >= REQ_LAST)
            begin
               state_next = css_pkg::CSS_STANDBY; // RULE_10
            end
         end
         css_pkg::CSS_TRANSFER:
         begin
            wdog_next = rx_req_valid ? TIMER_RST_F()
                                     : wdog_reg + 32'h0000_0001;
            if (rx_req_valid)
            begin
               level_next = rx_req_level; // RULE_12
            end
            if (fod_reg)
            begin
               state_next = css_pkg::CSS_FOD_FAULT; // RULE_05
            end
            else if (any_error)
            begin
               state_next = css_pkg::CSS_ERR_FAULT; // RULE_06
            end
            else if (rx_end_power)
            begin
               state_next = css_pkg::CSS_COMPLETE; // RULE_08
            end
            else if (!rx_req_valid && wdog_reg >= REQ_LAST)
            begin
               state_next = css_pkg::CSS_STANDBY; // RULE_10
            end
         end
         css_pkg::CSS_FOD_FAULT,
         css_pkg::CSS_ERR_FAULT,
         css_pkg::CSS_COMPLETE:
         begin
         end
         default:
         begin
            state_next = css_pkg::CSS_STANDBY;
         end
      endcase
      // removal overrides everything once init is done
      if (!present_reg && state_reg != css_pkg::CSS_INIT)
      begin
         state_next = css_pkg::CSS_STANDBY; // RULE_09
      end
      if (state_next != state_reg || (state_reg != css_pkg::CSS_INIT
                                      && timer_reg >= BLINK_LAST))
      begin
         timer_next = TIMER_RST_F();
      end
      if (state_next != css_pkg::CSS_TRANSFER)
      begin
         level_next = css_pkg::LEVEL_RST;
      end
      if (state_next != state_reg)
      begin
         wdog_next = TIMER_RST_F();
      end
   end

   function automatic logic [31:0] TIMER_RST_F();
      return css_pkg::TIMER_RST;
   endfunction

   // indicator and power drive, registered from the next state
   always_comb
   begin
      green_next = 1'b0;
      red_next   = 1'b0;
      pwr_next   = 1'b0;
      case (state_next)
         css_pkg::CSS_INIT:      green_next = 1'b1; // RULE_01
         css_pkg::CSS_STANDBY:   green_next = 1'b0; // RULE_02
         css_pkg::CSS_CONFIG:    green_next = 1'b0;
         css_pkg::CSS_TRANSFER:
         begin
            green_next = blink_on; // RULE_04
            pwr_next   = present_reg; // RULE_13
         end
         css_pkg::CSS_FOD_FAULT: red_next = blink_on; // RULE_05
         css_pkg::CSS_ERR_FAULT: red_next = 1'b1; // RULE_06
         css_pkg::CSS_COMPLETE:  green_next = 1'b1; // RULE_08
         default:
         begin
            green_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= css_pkg::CSS_INIT;
         timer_reg <= css_pkg::TIMER_RST;
         wdog_reg  <= css_pkg::TIMER_RST;
         level_reg <= css_pkg::LEVEL_RST;
         green_reg <= 1'b1;
         red_reg   <= 1'b0;
         pwr_reg   <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         wdog_reg  <= wdog_next;
         level_reg <= level_next;
         green_reg <= green_next;
         red_reg   <= red_next;
         pwr_reg   <= pwr_next;
      end
   end

   assign led_green     = green_reg;
   assign led_red       = red_reg;
   assign power_en      = pwr_reg;
   // level is forced to zero outside transfer, so it never exceeds the request
   assign power_level   = pwr_reg ? level_reg : css_pkg::LEVEL_RST;
   assign session_state = state_reg;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   a_init_green: assert property ( // RULE_01
      state_reg == css_pkg::CSS_INIT |-> led_green && !led_red)
      else $error("green not lit during init");

   a_init_exit: assert property ( // RULE_01
      state_reg == css_pkg::CSS_INIT && timer_reg == INIT_LAST
      |=> state_reg == css_pkg::CSS_STANDBY)
      else $error("init did not end on time");

   a_standby_dark: assert property ( // RULE_02
      state_reg == css_pkg::CSS_STANDBY
      |-> !led_green && !led_red && !power_en)
      else $error("standby not dark");

   a_config_first: assert property ( // RULE_03
      $rose(power_en) |-> $past(state_reg) == css_pkg::CSS_CONFIG
                          || $past(state_reg) == css_pkg::CSS_TRANSFER)
      else $error("power before instructions");

   a_fod_abort: assert property ( // RULE_05
      state_reg == css_pkg::CSS_TRANSFER && fod_reg && present_reg
      |=> state_reg == css_pkg::CSS_FOD_FAULT && !power_en && !led_green)
      else $error("foreign object not aborting");

   a_err_steady: assert property ( // RULE_06
      state_reg == css_pkg::CSS_ERR_FAULT
      |-> led_red && !led_green && !power_en)
      else $error("error indicator wrong");

   a_err_entry: assert property ( // RULE_07
      state_reg == css_pkg::CSS_TRANSFER && present_reg && !fod_reg
      && over_temp |=> state_reg == css_pkg::CSS_ERR_FAULT)
      else $error("error not aborting transfer");

   a_done_green: assert property ( // RULE_08
      state_reg == css_pkg::CSS_COMPLETE
      |-> led_green && !led_red && !power_en)
      else $error("complete indicator wrong");

   a_removal_stby: assert property ( // RULE_09
      !present_reg && state_reg != css_pkg::CSS_INIT
      |=> state_reg == css_pkg::CSS_STANDBY)
      else $error("removal not back to standby");

   a_req_timeout: assert property ( // RULE_10
      state_reg == css_pkg::CSS_TRANSFER && wdog_reg >= REQ_LAST
      && !rx_req_valid |=> state_reg != css_pkg::CSS_TRANSFER)
      else $error("stalled requests did not end session");

   a_level_follow: assert property ( // RULE_12
      state_reg == css_pkg::CSS_TRANSFER && rx_req_valid
      ##1 state_reg == css_pkg::CSS_TRANSFER
      |-> power_level == $past(rx_req_level))
      else $error("level did not follow request");

   a_blink_phase: assert property ( // RULE_14
      state_reg == css_pkg::CSS_TRANSFER
      |-> led_green == (timer_reg < BLINK_HALF))
      else $error("blink phase wrong");

endmodule // css_session_ctrl

/* tb/css_rx_model.sv */
// behavioural wireless receiver facing the session controller
`timescale 1ns/1ps

module css_rx_model (
   input  wire logic       ref_clk,
   input  wire logic       place,
   input  wire logic       cfg_en,
   input  wire logic       req_on,
   input  wire logic [7:0] lvl_in,
   output logic            rx_present_pin,
   output logic            rx_config_done,
   output logic            rx_req_valid,
   output logic [7:0]      rx_req_level
);
   logic [2:0] gap_reg;
   logic       fire;

   initial
   begin
      rx_present_pin = 1'b0;
      rx_config_done = 1'b0;
      rx_req_valid   = 1'b0;
      rx_req_level   = 8'h00;
      gap_reg        = 3'h0;
   end

   assign fire = place & req_on & (gap_reg == 3'h7);

   // controls settle at the falling edge and are taken here on the rising
   // one, so the model never races the bench; the design sees the update
   // one edge later
   always @(posedge ref_clk)
   begin
      rx_present_pin <= place;
      rx_config_done <= place & cfg_en;
      gap_reg        <= gap_reg + 3'h1;
      rx_req_valid   <= fire;
      // level is junk between requests so a stale value cannot pass
      rx_req_level   <= fire ? lvl_in : ~rx_req_level;
   end
endmodule // css_rx_model

/* tb/tb_charge_session_status_fsm.sv */
// self-checking bench for the charge session controller
`timescale 1ns/1ps

module tb_charge_session_status_fsm;
   typedef struct {
      css_pkg::css_state_t st;
      logic g, r, p;
      logic [7:0] lv;
      logic [2:0] m;
   } css_note_t;

   localparam int BLK = 16;
   logic ref_clk, resetn, place, cfg_en, req_on, fod, end_pwr;
   logic [7:0] lvl_in, lv, power_level, rx_req_level;
   logic [4:0] err;
   logic rx_present_pin, rx_config_done, rx_req_valid;
   logic led_green, led_red, power_en;
   css_pkg::css_state_t session_state;
   logic [31:0] seed;
   int miscompares, cmp_count, n;
   css_note_t q[$];
   event note_ev;

   always #5 ref_clk = ~ref_clk;

   css_rx_model rx (.ref_clk(ref_clk), .place(place), .cfg_en(cfg_en),
      .req_on(req_on), .lvl_in(lvl_in), .rx_present_pin(rx_present_pin),
      .rx_config_done(rx_config_done), .rx_req_valid(rx_req_valid),
      .rx_req_level(rx_req_level));

   css_session_ctrl #(.INIT_CYC(20), .BLINK_CYC(BLK), .REQ_TIMEOUT_CYC(40))
   dut (.ref_clk(ref_clk), .resetn(resetn), .rx_present_pin(rx_present_pin),
      .fod_detect_pin(fod), .rx_config_done(rx_config_done),
      .rx_req_valid(rx_req_valid), .rx_req_level(rx_req_level),
      .rx_end_power(end_pwr), .comm_error(err[0]), .over_volt(err[1]),
      .over_curr(err[2]), .over_power(err[3]), .over_temp(err[4]),
      .led_green(led_green), .led_red(led_red), .power_en(power_en),
      .power_level(power_level), .session_state(session_state));

   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic note(css_pkg::css_state_t s, logic g, logic r, logic p,
                       logic [7:0] l, logic [2:0] m);
      q.push_back('{s, g, r, p, l, m});
      ->note_ev;
   endtask

   // m: bit0 state, bit1 indicators, bit2 level; power_en always checked
   always @(note_ev)
   begin
      while (q.size() > 0)
      begin
         css_note_t x;
         x = q.pop_front();
         if (x.m[0]) chk("state", 8'(x.st), 8'(session_state));
         if (x.m[1]) chk("green", 8'(x.g), 8'(led_green));
         if (x.m[1]) chk("red", 8'(x.r), 8'(led_red));
         if (x.m[2]) chk("level", x.lv, power_level);
         chk("power_en", 8'(x.p), 8'(power_en));
      end
   end

   task automatic cyc(int k);
      repeat (k) @(negedge ref_clk);
   endtask

   task automatic count_on(bit red, output int c);
      c = 0;
      repeat (BLK)
      begin
         @(negedge ref_clk);
         c += red ? int'(led_red === 1'b1) : int'(led_green === 1'b1);
      end
   endtask

   task automatic go_transfer();
      place = 1'b1;
      cfg_en = 1'b1;
      req_on = 1'b1;
      for (int i = 0; i < 20 && session_state !== css_pkg::CSS_TRANSFER; i++)
         cyc(1);
      note(css_pkg::CSS_TRANSFER, 1'b1, 1'b0, 1'b1, 8'h00, 3'b011);
   endtask

   task automatic leave();
      place = 1'b0;
      cyc(8);
      note(css_pkg::CSS_STANDBY, 1'b0, 1'b0, 1'b0, 8'h00, 3'b011);
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      repeat (6000) @(posedge ref_clk);
      miscompares++;
      $display("[ERR] watchdog expected finish seen hang");
      test_done();
   end

   initial
   begin
      {ref_clk, resetn, place, cfg_en, req_on, fod, end_pwr} = 7'h00;
      err = 5'h00;
      lvl_in = 8'h00;
      seed = 32'h6811;
      cyc(5);
      note(css_pkg::CSS_INIT, 1'b1, 1'b0, 1'b0, 8'h00, 3'b011);
      resetn = 1'b1;
      cyc(16);
      note(css_pkg::CSS_INIT, 1'b1, 1'b0, 1'b0, 8'h00, 3'b011);
      cyc(8);
      note(css_pkg::CSS_STANDBY, 1'b0, 1'b0, 1'b0, 8'h00, 3'b011);
      $display("test init done");
      place = 1'b1;
      cyc(12);
      note(css_pkg::CSS_CONFIG, 1'b0, 1'b0, 1'b0, 8'h00, 3'b001);
      go_transfer();
      repeat (4)
      begin
         seed = lfsr(seed);
         lvl_in = seed[7:0];
         @(posedge ref_clk iff rx_req_valid === 1'b1);
         lv = rx_req_level;
         cyc(1);
         note(css_pkg::CSS_TRANSFER, 1'b0, 1'b0, 1'b1, lv, 3'b101);
      end
      count_on(0, n);
      chk("green_blink", 8'(BLK / 2), 8'(n));
      end_pwr = 1'b1;
      cyc(3);
      note(css_pkg::CSS_COMPLETE, 1'b1, 1'b0, 1'b0, 8'h00, 3'b011);
      end_pwr = 1'b0;
      count_on(0, n);
      chk("green_steady", 8'(BLK), 8'(n));
      leave();
      $display("test transfer done");
      go_transfer();
      fod = 1'b1;
      cyc(6);
      note(css_pkg::CSS_FOD_FAULT, 1'b0, 1'b0, 1'b0, 8'h00, 3'b001);
      fod = 1'b0;
      count_on(1, n);
      chk("red_blink", 8'(BLK / 2), 8'(n));
      leave();
      $display("test fod done");
      for (int i = 0; i < 5; i++)
      begin
         go_transfer();
         err = 5'h01 << i;
         cyc(3);
         note(css_pkg::CSS_ERR_FAULT, 1'b0, 1'b1, 1'b0, 8'h00,
              3'b011);
         err = 5'h00;
         count_on(1, n);
         chk("red_steady", 8'(BLK), 8'(n));
         leave();
      end
      $display("test errors done");
      go_transfer();
      req_on = 1'b0;
      cfg_en = 1'b0;
      cyc(30);
      note(css_pkg::CSS_TRANSFER, 1'b0, 1'b0, 1'b1, 8'h00, 3'b001);
      cyc(15);
      // receiver still present: search finds it again, no instructions yet
      note(css_pkg::CSS_CONFIG, 1'b0, 1'b0, 1'b0, 8'h00, 3'b001);
      leave();
      $display("test timeout done");
      cyc(2);
      test_done();
   end
endmodule // tb_charge_session_status_fsm
